// ---- rtl/cdb_pkg.sv ----
// ***************************************************************
// shared constants of the complementary output stage
// ***************************************************************
package cdb_pkg;
    localparam int NUM_CH = 3;                // complementary channel count
    localparam int DT_W = 8;                  // deadtime field width
    localparam int MODE_W = 3;                // output mode field width
    localparam int LOCK_W = 2;                // protection level field width
    localparam int SYNC_STAGES = 2;           // flops in each synchroniser

    // protection levels, each freezing more than the one before
    localparam logic [LOCK_W-1:0] LOCK_OFF = 2'h0;
    localparam logic [LOCK_W-1:0] LOCK_L1 = 2'h1;   // deadtime, break, idle
    localparam logic [LOCK_W-1:0] LOCK_L2 = 2'h2;   // + polarities, off states
    localparam logic [LOCK_W-1:0] LOCK_L3 = 2'h3;   // + output modes

    localparam logic [DT_W-1:0] DT_ZERO = 8'h00;    // counter idle value
    localparam logic [DT_W-1:0] DT_ONE = 8'h01;     // counter step
    localparam logic [MODE_W-1:0] MODE_RST = 3'h0;  // frozen mode after reset

    typedef logic [MODE_W-1:0] cdb_mode_t;     // one channel's output mode
endpackage

// ---- rtl/cdb_dt_if.sv ----
// ***************************************************************
// request and result of one channel's deadtime generator
// ***************************************************************
interface cdb_dt_if;
    logic want_main;   // main output should be active
    logic want_compl;  // complementary output should be active
    logic act_main;    // main output active after deadtime
    logic act_compl;   // complementary output active after deadtime

    modport core (output want_main, output want_compl, input act_main, input act_compl);
    modport gen (input want_main, input want_compl, output act_main, output act_compl);
endinterface

// ---- rtl/cdb_sync.sv ----
// ***************************************************************
// two flop synchroniser for levels from outside the clock domain
// ***************************************************************
module cdb_sync (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic async_i,
    output logic sync_o
);
    import cdb_pkg::*;

    logic [SYNC_STAGES-1:0] stage_q;  // stage 0 feeds only stage 1

    // shift chain, frozen with the clock enable
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            stage_q <= '0;
        end else if (clk_en_i) begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], async_i};
        end
    end

    assign sync_o = stage_q[SYNC_STAGES-1];
endmodule

// ---- rtl/cdb_deadtime.sv ----
// ***************************************************************
// deadtime generator of one channel
// ***************************************************************
module cdb_deadtime (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [cdb_pkg::DT_W-1:0] dt_i,
    cdb_dt_if.gen dt_if
);
    import cdb_pkg::*;

    logic [1:0] prev_q;          // last request seen
    logic [DT_W-1:0] cnt_q;      // remaining deadtime cycles
    logic [DT_W-1:0] cnt_d;
    logic changed_w;             // request differs from last cycle
    logic done_w;                // deadtime has run out

    assign changed_w = ({dt_if.want_main, dt_if.want_compl} != prev_q);
    // every request change restarts the count, so short pulses vanish
    assign cnt_d = changed_w ? dt_i : ((cnt_q != DT_ZERO) ? cnt_q - DT_ONE : cnt_q);
    assign done_w = (cnt_d == DT_ZERO);

    // rising edges wait out the count, falling edges pass at once
    assign dt_if.act_main = dt_if.want_main & done_w;
    assign dt_if.act_compl = dt_if.want_compl & done_w;

    // counter and request history
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prev_q <= 2'h0;
            cnt_q <= DT_ZERO;
        end else if (clk_en_i) begin
            prev_q <= {dt_if.want_main, dt_if.want_compl};
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- rtl/cdb_output_stage.sv ----
// Contract
// - each output has its own polarity bit
// - per channel 8-bit deadtime generator from reference
// - main rising edge delayed by deadtime
// - complementary rising edge delayed after reference fall
// - deadtime longer than pulse swallows pulse
// - one deadtime value shared by all channels
// - deadtime when both enables are set, or when master enable is low
// - falling master enable also passes through deadtime
// - single enabled output bypasses deadtime, other inactive
// - lone complementary output follows reference uninverted
// - mode and enables preloaded, copied on commutation
// - commutation from software or trigger rising edge
// - commutation sets flag, interrupt when enabled
// - break off after reset, enable and polarity
// - active break clears master enable asynchronously
// - idle levels once master enable is low
// - break forces inactive first, idle after longer deadtime
// - break sets flag, interrupt when enabled
// - auto re-enable on update event, else software
// - active break blocks master enable and flag clear
// - lock field written once, three freeze levels
module cdb_output_stage (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // reference waveforms from the compare logic, same clock
    input wire logic [cdb_pkg::NUM_CH-1:0] ref_wave_i,
    // configuration, taken on cfg_wr_i unless locked; interrupt enables always taken
    input wire logic cfg_wr_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_polarity_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] compl_polarity_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_idle_level_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] compl_idle_level_i,
    input wire logic off_state_idle_sel_i,
    input wire logic off_state_run_sel_i,
    input wire logic [cdb_pkg::DT_W-1:0] deadtime_value_i,
    input wire logic break_enable_i,
    input wire logic break_polarity_i,
    input wire logic auto_output_reenable_i,
    input wire logic commutation_irq_en_i,
    input wire logic break_irq_en_i,
    // preload side of the six-step configuration
    input wire cdb_pkg::cdb_mode_t [cdb_pkg::NUM_CH-1:0] output_mode_sel_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_out_en_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] compl_out_en_i,
    // write-once protection
    input wire logic lock_wr_i,
    input wire logic [cdb_pkg::LOCK_W-1:0] lock_level_i,
    // master enable writes and events
    input wire logic moe_set_i,
    input wire logic moe_clr_i,
    input wire logic commutation_sw_generate_i,
    input wire logic trigger_input_i,
    input wire logic update_event_i,
    input wire logic break_input_i,
    input wire logic commutation_flag_clr_i,
    input wire logic break_flag_clr_i,
    // pins toward the gate drivers
    output logic [cdb_pkg::NUM_CH-1:0] main_out_o,
    output logic [cdb_pkg::NUM_CH-1:0] main_oe_o,
    output logic [cdb_pkg::NUM_CH-1:0] compl_out_o,
    output logic [cdb_pkg::NUM_CH-1:0] compl_oe_o,
    // active configuration and status
    output cdb_pkg::cdb_mode_t [cdb_pkg::NUM_CH-1:0] output_mode_act_o,
    output logic [cdb_pkg::NUM_CH-1:0] main_out_en_act_o,
    output logic [cdb_pkg::NUM_CH-1:0] compl_out_en_act_o,
    output logic master_output_enable_o,
    output logic commutation_flag_o,
    output logic break_flag_o,
    output logic commutation_irq_o,
    output logic break_irq_o,
    output logic [cdb_pkg::LOCK_W-1:0] lock_level_o
);
    import cdb_pkg::*;

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    logic [NUM_CH-1:0] main_pol_q;       // main polarity, 1 = active low
    logic [NUM_CH-1:0] compl_pol_q;      // complementary polarity
    logic [NUM_CH-1:0] main_idle_q;      // main pin level when idle
    logic [NUM_CH-1:0] compl_idle_q;     // complementary pin level when idle
    logic off_state_idle_sel_q;                        // keep enables high when idle
    logic off_state_run_sel_q;                        // keep enables high when off in run
    logic [DT_W-1:0] dt_q;               // shared deadtime
    logic brk_en_q;                      // break circuit enabled
    logic brk_pol_q;                     // break active level
    logic aoe_q;                         // auto re-enable on update
    logic com_ie_q;                      // commutation interrupt enable
    logic brk_ie_q;                      // break interrupt enable
    logic [LOCK_W-1:0] lock_q;           // protection level
    logic lock_done_q;                   // lock field already written

    // lock decode: which groups are still writable
    logic wr_l1_w;                       // deadtime, break, idle group
    logic wr_l2_w;                       // polarities and off states
    logic wr_l3_w;                       // output mode preloads
    assign wr_l1_w = cfg_wr_i & (lock_q < LOCK_L1);
    assign wr_l2_w = cfg_wr_i & (lock_q < LOCK_L2);
    assign wr_l3_w = lock_q < LOCK_L3;

    // configuration capture; the lock only blocks, it never clears
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            main_pol_q <= '0;
            compl_pol_q <= '0;
            main_idle_q <= '0;
            compl_idle_q <= '0;
            off_state_idle_sel_q <= 1'b0;
            off_state_run_sel_q <= 1'b0;
            dt_q <= DT_ZERO;
            brk_en_q <= 1'b0;
            brk_pol_q <= 1'b0;
            aoe_q <= 1'b0;
            com_ie_q <= 1'b0;
            brk_ie_q <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_l1_w) begin
                dt_q <= deadtime_value_i;
                brk_en_q <= break_enable_i;
                brk_pol_q <= break_polarity_i;
                aoe_q <= auto_output_reenable_i;
                main_idle_q <= main_idle_level_i;
                compl_idle_q <= compl_idle_level_i;
            end
            if (wr_l2_w) begin
                main_pol_q <= main_polarity_i;
                compl_pol_q <= compl_polarity_i;
                off_state_idle_sel_q <= off_state_idle_sel_i;
                off_state_run_sel_q <= off_state_run_sel_i;
            end
            if (cfg_wr_i) begin
                // interrupt enables are never protected
                com_ie_q <= commutation_irq_en_i;
                brk_ie_q <= break_irq_en_i;
            end
        end
    end

    // write-once lock field
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            lock_q <= LOCK_OFF;
            lock_done_q <= 1'b0;
        end else if (clk_en_i && lock_wr_i && !lock_done_q) begin
            lock_q <= lock_level_i;
            lock_done_q <= 1'b1;
        end
    end

    // ***************************************************************
    // commutation
    // ***************************************************************
    logic trig_s;            // synchronised trigger level
    logic trig_prev_q;       // trigger level one cycle back
    logic com_evt_w;         // commutation this cycle
    logic com_flag_q;
    logic com_irq_q;
    cdb_mode_t [NUM_CH-1:0] mode_act_q;
    logic [NUM_CH-1:0] men_act_q;    // active main enables
    logic [NUM_CH-1:0] cen_act_q;    // active complementary enables

    cdb_sync u_trig_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(trigger_input_i),
        .sync_o(trig_s)
    );

    // software strobe or rising trigger edge
    assign com_evt_w = commutation_sw_generate_i | (trig_s & ~trig_prev_q);

    // preload transfer, flag and interrupt; a set beats a clear
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            trig_prev_q <= 1'b0;
            mode_act_q <= '{default: MODE_RST};
            men_act_q <= '0;
            cen_act_q <= '0;
            com_flag_q <= 1'b0;
            com_irq_q <= 1'b0;
        end else if (clk_en_i) begin
            trig_prev_q <= trig_s;
            if (com_evt_w) begin
                // all channels switch together
                men_act_q <= main_out_en_i;
                cen_act_q <= compl_out_en_i;
                if (wr_l3_w) begin
                    mode_act_q <= output_mode_sel_i;
                end
            end
            com_flag_q <= com_evt_w | (com_flag_q & ~commutation_flag_clr_i);
            com_irq_q <= com_ie_q & (com_evt_w | (com_flag_q & ~commutation_flag_clr_i));
        end
    end

    // ***************************************************************
    // break and master output enable
    // ***************************************************************
    logic brk_async_w;       // raw break level, acts without a clock
    logic brk_pin_s;         // synchronised break pin
    logic brk_lvl_w;         // synchronised break active
    logic moe_q;             // master enable control bit
    logic moe_eff;           // resynchronised copy steering the outputs
    logic brk_flag_q;
    logic brk_irq_q;
    logic moe_set_ok_w;

    // the pin is used raw here on purpose: the clear must work with no clock
    assign brk_async_w = brk_en_q & (break_input_i == brk_pol_q);
    assign brk_lvl_w = brk_en_q & (brk_pin_s == brk_pol_q);
    // software write or update event with auto re-enable
    assign moe_set_ok_w = moe_set_i | (aoe_q & update_event_i);
    // force only until the resynced enable falls, then idle levels run via deadtime
    logic brk_force_w;
    assign brk_force_w = brk_async_w & moe_eff;

    cdb_sync u_brk_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(break_input_i),
        .sync_o(brk_pin_s)
    );

    // master enable: async clear by break, cleared at reset
    always_ff @(posedge ref_clk_i or posedge brk_async_w) begin
        if (brk_async_w) begin
            moe_q <= 1'b0;
        end else if (sys_rst_i) begin
            moe_q <= 1'b0;
        end else if (clk_en_i) begin
            if (brk_lvl_w) begin
                moe_q <= 1'b0;
            end else if (moe_set_ok_w) begin
                moe_q <= 1'b1;
            end else if (moe_clr_i) begin
                moe_q <= 1'b0;
            end
        end
    end

    // resync adds the extra cycles to the idle deadtime after a break
    cdb_sync u_moe_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .async_i(moe_q),
        .sync_o(moe_eff)
    );

    // break flag stays set while the break level holds
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            brk_flag_q <= 1'b0;
            brk_irq_q <= 1'b0;
        end else if (clk_en_i) begin
            brk_flag_q <= brk_lvl_w | (brk_flag_q & ~break_flag_clr_i);
            brk_irq_q <= brk_ie_q & (brk_lvl_w | (brk_flag_q & ~break_flag_clr_i));
        end
    end

    // ***************************************************************
    // per channel output selection
    // ***************************************************************
    logic [NUM_CH-1:0] main_act_q;   // main output active, before polarity
    logic [NUM_CH-1:0] compl_act_q;  // complementary active, before polarity
    logic [NUM_CH-1:0] main_oe_q;
    logic [NUM_CH-1:0] compl_oe_q;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            cdb_dt_if dt_if ();
            logic both_w;        // both outputs enabled
            logic use_dt_w;      // path goes through the deadtime
            logic idle_m_w;      // idle main level as an active state
            logic idle_c_w;      // idle complementary level as active state
            logic main_d;
            logic compl_d;
            logic main_oe_d;
            logic compl_oe_d;

            assign both_w = men_act_q[ch] & cen_act_q[ch];
            assign use_dt_w = ~moe_eff | both_w;
            assign idle_m_w = main_idle_q[ch] ^ main_pol_q[ch];
            // never both active, even when idle levels ask for it
            assign idle_c_w = (compl_idle_q[ch] ^ compl_pol_q[ch]) & ~idle_m_w;

            // run: complementary pair; idle: programmed levels
            assign dt_if.want_main = moe_eff ? ref_wave_i[ch] : idle_m_w;
            assign dt_if.want_compl = moe_eff ? ~ref_wave_i[ch] : idle_c_w;

            // single output redirect bypasses the generator
            assign main_d = use_dt_w ? dt_if.act_main : (men_act_q[ch] & ref_wave_i[ch]);
            assign compl_d = use_dt_w ? dt_if.act_compl
                                      : (cen_act_q[ch] & ref_wave_i[ch]);

            // enables: in run on when enabled, else by off-state selection
            assign main_oe_d = moe_eff ? (men_act_q[ch] | off_state_run_sel_q) : off_state_idle_sel_q;
            assign compl_oe_d = moe_eff ? (cen_act_q[ch] | off_state_run_sel_q) : off_state_idle_sel_q;

            cdb_deadtime u_dt (
                .ref_clk_i(ref_clk_i),
                .sys_rst_i(sys_rst_i),
                .clk_en_i(clk_en_i),
                .dt_i(dt_q),
                .dt_if(dt_if)
            );

            // active states, forced inactive at once by a break
            always_ff @(posedge ref_clk_i or posedge brk_force_w) begin
                if (brk_force_w) begin
                    main_act_q[ch] <= 1'b0;
                    compl_act_q[ch] <= 1'b0;
                end else if (sys_rst_i) begin
                    main_act_q[ch] <= 1'b0;
                    compl_act_q[ch] <= 1'b0;
                end else if (clk_en_i) begin
                    main_act_q[ch] <= main_d;
                    compl_act_q[ch] <= compl_d;
                end
            end

            // enables follow one cycle later, no async path needed
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    main_oe_q[ch] <= 1'b0;
                    compl_oe_q[ch] <= 1'b0;
                end else if (clk_en_i) begin
                    main_oe_q[ch] <= main_oe_d;
                    compl_oe_q[ch] <= compl_oe_d;
                end
            end
        end
    endgenerate

    // ***************************************************************
    // outputs
    // ***************************************************************
    // polarity is a quasi-static register, so the xor cannot glitch
    assign main_out_o = main_act_q ^ main_pol_q;
    assign compl_out_o = compl_act_q ^ compl_pol_q;
    assign main_oe_o = main_oe_q;
    assign compl_oe_o = compl_oe_q;
    assign output_mode_act_o = mode_act_q;
    assign main_out_en_act_o = men_act_q;
    assign compl_out_en_act_o = cen_act_q;
    // readback lags the control bit by the resync stages
    assign master_output_enable_o = moe_eff;
    assign commutation_flag_o = com_flag_q;
    assign break_flag_o = brk_flag_q;
    assign commutation_irq_o = com_irq_q;
    assign break_irq_o = brk_irq_q;
    assign lock_level_o = lock_q;
endmodule

// ---- dv/cdb_checker.sv ----
// ****
// port checker of the output stage
// ****
module cdb_checker import cdb_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic commutation_sw_generate_i,
    input wire logic commutation_flag_clr_i,
    input wire logic break_flag_clr_i,
    input wire logic moe_set_i,
    input wire logic update_event_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_out_en_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_out_en_act_o,
    input wire logic master_output_enable_o,
    input wire logic commutation_flag_o,
    input wire logic commutation_irq_o,
    input wire logic break_flag_o,
    input wire logic break_irq_o,
    input wire logic [cdb_pkg::LOCK_W-1:0] lock_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // software strobe answered one edge later
    property p_comm; commutation_sw_generate_i |=> commutation_flag_o; endproperty
    a_comm: assert property (p_comm) else $error("commutation flag missing");
    property p_copy;
        commutation_sw_generate_i |=> main_out_en_act_o == $past(main_out_en_i);
    endproperty
    a_copy: assert property (p_copy) else $error("preload not copied");
    property p_chold; commutation_flag_o && !commutation_flag_clr_i |=> commutation_flag_o; endproperty
    a_chold: assert property (p_chold) else $error("commutation flag lost");
    property p_cirq; commutation_irq_o |-> commutation_flag_o; endproperty
    a_cirq: assert property (p_cirq) else $error("commutation irq without flag");
    property p_birq; break_irq_o |-> break_flag_o; endproperty
    a_birq: assert property (p_birq) else $error("break irq without flag");
    property p_bhold; break_flag_o && !break_flag_clr_i |=> break_flag_o; endproperty
    a_bhold: assert property (p_bhold) else $error("break flag lost");
    // readback lag is three edges after the set strobe
    property p_moe;
        $rose(master_output_enable_o) |-> $past(moe_set_i, 3) || $past(update_event_i, 3);
    endproperty
    a_moe: assert property (p_moe) else $error("master enable rose uncaused");
    property p_lock; lock_level_o != 2'h0 |=> $stable(lock_level_o); endproperty
    a_lock: assert property (p_lock) else $error("lock rewritten");
    property p_rst; $fell(sys_rst_i) |-> !master_output_enable_o && !break_flag_o; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    cover property (commutation_flag_o && commutation_irq_o);
    cover property ($rose(break_flag_o));
    cover property ($rose(master_output_enable_o));
endmodule
bind cdb_output_stage cdb_checker i_chk (.*);

// ---- dv/cdb_gate_drv.sv ----
// ****
// gate drivers and break alarm
// ****
module cdb_gate_drv import cdb_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] main_out_i,
    input wire logic [cdb_pkg::NUM_CH-1:0] compl_out_i,
    input wire logic alarm_i,
    output logic break_input_o,
    output logic [7:0] overlap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // alarm level passed raw, works without clock
    assign break_input_o = alarm_i;
    // both legs of bridge 0 on would short the supply
    initial overlap_o = 8'h00;
    always @(posedge ref_clk_i) if (main_out_i[0] && compl_out_i[0]) overlap_o <= overlap_o + 8'h01;
endmodule

// ---- dv/testbench.sv ----
// ****
// self-checking bench of the output stage
// ****
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cdb_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;  // never gated here
    logic off_state_idle_sel_i = 1'b1, off_state_run_sel_i = 1'b0;  // oe kept when idle
    logic break_enable_i = 1'b1, break_polarity_i = 1'b1, auto_output_reenable_i = 1'b0;
    logic commutation_irq_en_i = 1'b1, break_irq_en_i = 1'b1, trigger_input_i = 1'b0, alarm = 1'b0;
    logic [NUM_CH-1:0] ref_wave_i = 3'h0, main_polarity_i = 3'h0, compl_polarity_i = 3'h0;
    logic [NUM_CH-1:0] main_idle_level_i = 3'h1, compl_idle_level_i = 3'h0;
    logic [NUM_CH-1:0] main_out_en_i = 3'h3, compl_out_en_i = 3'h5;  // both, main, compl
    logic [DT_W-1:0] deadtime_value_i = 8'h03;
    logic [LOCK_W-1:0] lock_level_i = 2'h1;
    cdb_mode_t [NUM_CH-1:0] output_mode_sel_i = 9'h1BE, output_mode_act_o;
    logic [7:0] pls = 8'h00;  // one bit per strobe
    wire logic cfg_wr_i, lock_wr_i, moe_set_i, moe_clr_i, commutation_sw_generate_i;
    wire logic update_event_i, commutation_flag_clr_i, break_flag_clr_i, break_input_i;
    assign {break_flag_clr_i, commutation_flag_clr_i, update_event_i, commutation_sw_generate_i,
        moe_clr_i, moe_set_i, lock_wr_i, cfg_wr_i} = pls;
    logic [NUM_CH-1:0] main_out_o, main_oe_o, compl_out_o, compl_oe_o;
    logic [NUM_CH-1:0] main_out_en_act_o, compl_out_en_act_o;
    logic master_output_enable_o, commutation_flag_o, break_flag_o, commutation_irq_o, break_irq_o;
    logic [LOCK_W-1:0] lock_level_o;
    logic [7:0] overlap;
    int fails = 0, checked = 0, n;
    always #25 ref_clk_i = ~ref_clk_i;
    cdb_output_stage i_dut (.*);
    cdb_gate_drv i_drv (.ref_clk_i(ref_clk_i), .main_out_i(main_out_o), .compl_out_i(compl_out_o),
        .alarm_i(alarm), .break_input_o(break_input_i), .overlap_o(overlap));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic pulse(input int b);
        @(posedge ref_clk_i) pls <= 8'h01 << b;
        @(posedge ref_clk_i) pls <= 8'h00;
    endtask
    task automatic cfg(input logic [DT_W-1:0] dt, input logic au, input logic [NUM_CH-1:0] mp);
        @(posedge ref_clk_i) deadtime_value_i <= dt;
        auto_output_reenable_i <= au;
        main_polarity_i <= mp;
        pulse(0);
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // cycles until a watched pin goes high, bounded
    task automatic wait_hi(input logic [5:0] m, output int c);
        c = 0;
        do begin
            step(1);
            c++;
        end while (({compl_out_o, main_out_o} & m) == 6'h00 && c < 20);
        if (c == 20) begin
            fails++;
            stop_test();
        end
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        step(1);
        chk({master_output_enable_o, break_flag_o, lock_level_o}, 9'h0);
        cfg(8'h03, 1'b0, 3'h0);
        pulse(4);
        step(1);
        chk({main_out_en_act_o, compl_out_en_act_o}, 9'h1D);
        chk(output_mode_act_o, 9'h1BE);
        chk({commutation_flag_o, commutation_irq_o}, 9'h3);
        pulse(6);
        pulse(2);
        step(3);
        chk({commutation_flag_o, master_output_enable_o}, 9'h1);
        chk(compl_oe_o, 3'h5);
        $display("test commutation done");
        @(posedge ref_clk_i) ref_wave_i <= 3'h7;
        wait_hi(6'h01, n);
        chk(n, 4);
        chk({compl_out_o, main_out_o}, 9'h23);
        @(posedge ref_clk_i) ref_wave_i <= 3'h0;
        wait_hi(6'h08, n);
        chk(n, 4);
        chk({compl_out_o, main_out_o}, 9'h08);
        @(posedge ref_clk_i) ref_wave_i <= 3'h1;
        @(posedge ref_clk_i) ref_wave_i <= 3'h1;
        @(posedge ref_clk_i) ref_wave_i <= 3'h0;
        repeat (6) begin
            step(1);
            chk(main_out_o[0], 1'b0);
        end
        $display("test deadtime done");
        @(posedge ref_clk_i) ref_wave_i <= 3'h1;
        wait_hi(6'h01, n);
        @(posedge ref_clk_i) alarm <= 1'b1;
        #1;
        chk({compl_out_o[0], main_out_o[0]}, 9'h0);
        step(3);
        chk({break_flag_o, break_irq_o, master_output_enable_o}, 9'h6);
        pulse(2);
        pulse(7);
        step(3);
        chk({break_flag_o, master_output_enable_o}, 9'h2);
        step(8);
        chk({main_oe_o[0], main_out_o[0], compl_out_o[0]}, 9'h6);
        chk(compl_oe_o, 3'h7);
        @(posedge ref_clk_i) alarm <= 1'b0;
        step(4);
        pulse(7);
        pulse(5);
        step(3);
        chk({break_flag_o, master_output_enable_o}, 9'h0);
        cfg(8'h03, 1'b1, 3'h2);
        pulse(5);
        step(3);
        chk(master_output_enable_o, 1'b1);
        step(2);
        chk(main_out_o[1], 1'b1);
        $display("test break done");
        pulse(1);
        @(posedge ref_clk_i) lock_level_i <= 2'h3;
        pulse(1);
        step(1);
        chk(lock_level_o, 9'h1);
        cfg(8'h05, 1'b1, 3'h2);
        @(posedge ref_clk_i) ref_wave_i <= 3'h0;
        step(8);
        @(posedge ref_clk_i) ref_wave_i <= 3'h1;
        wait_hi(6'h01, n);
        chk(n, 4);
        @(posedge ref_clk_i) trigger_input_i <= 1'b1;
        n = 0;
        while (commutation_flag_o !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        chk(commutation_flag_o, 1'b1);
        chk(overlap, 8'h00);
        $display("test lock and trigger done");
        stop_test();
    end
endmodule
